// file: rtl/jtl_pkg.sv
// shared constants and types for the serial link configuration block
package jtl_pkg;
	// ****************************************
	// register offsets
	// ****************************************
	localparam logic [7:0] A_READOUT = 8'h00;
	localparam logic [7:0] A_OVR_SEL = 8'h0d;
	localparam logic [7:0] A_WORD2 = 8'h13;
	localparam logic [7:0] A_TRIP = 8'h1f;
	localparam logic [7:0] A_LANE = 8'h26;
	localparam logic [7:0] A_OVRD = 8'h27;
	localparam logic [7:0] A_SCR = 8'h28;
	localparam logic [7:0] A_OCT = 8'h2c;
	localparam logic [7:0] A_MFL = 8'h2d;
	localparam logic [7:0] A_CLASS = 8'h30;
	localparam logic [7:0] A_RESYNC = 8'h36;
	localparam logic [7:0] A_LTEST = 8'h37;
	// ****************************************
	// reset values and writable bits
	// ****************************************
	localparam logic [7:0] RST_ZERO = 8'h00;
	localparam logic [7:0] RST_TRIP = 8'hff;
	localparam logic [7:0] RST_CLASS = 8'h40;
	localparam logic [7:0] M_BIT0 = 8'h01;
	localparam logic [7:0] M_OVRD = 8'h03;
	localparam logic [7:0] M_SCR = 8'h80;
	localparam logic [7:0] M_MFL = 8'h1f;
	localparam logic [7:0] M_CLASS = 8'he0;
	localparam logic [7:0] M_RESYNC = 8'hc0;
	localparam logic [7:0] M_LTEST = 8'hf7;
	// ****************************************
	// field positions
	// ****************************************
	localparam int B_IDLE_SEL = 5;
	localparam int B_LONG_TEST = 4;
	localparam int B_REVERSE = 3;
	localparam int B_LANE_MK = 2;
	localparam int B_FRAME_MK = 1;
	localparam int B_ILA_OFF = 0;
	localparam int B_CTRL_K = 1;
	localparam int B_CTRL_F = 0;
	localparam int B_SCR_EN = 7;
	localparam int B_RESYNC = 7;
	localparam int B_LMFC_IGN = 6;
	localparam int B_FLIP = 4;
	localparam int B_PF_ANALOG = 2;
	localparam int B_PF_ARM = 1;
	localparam int B_PF_ONCE = 0;
	// ****************************************
	// codes and counts
	// ****************************************
	localparam logic [7:0] K285 = 8'hbc;
	localparam logic [7:0] K283 = 8'h7c;
	localparam logic [7:0] K287 = 8'hfc;
	localparam logic [7:0] K280 = 8'h1c;
	localparam logic [7:0] D215 = 8'hb5;
	localparam logic [15:0] IDLE_STD = 16'hbcbc;
	localparam logic [15:0] IDLE_ALT = 16'hbc50;
	localparam logic [15:0] CLK_PAT = 16'haaaa;
	localparam logic [15:0] PRBS_SEED = 16'h7fff;
	localparam logic [4:0] K_DEF_10X = 5'h11;
	localparam logic [4:0] K_DEF_20X = 5'h09;
	localparam logic [1:0] ILA_LAST_MF = 2'h3;
	localparam logic [14:0] FULL_SCALE = 15'h7fff;
	localparam logic [7:0] TRIP_DIV = 8'hff;
	localparam logic [3:0] RPAT_LAST = 4'ha;
	localparam logic [7:0] RPAT [12] = '{8'hbe, 8'hd7, 8'h23, 8'h47, 8'h6b, 8'h8f, 8'hb3, 8'h14,
		8'h5e, 8'hfb, 8'h35, 8'h59};
	localparam logic [2:0] LT_NORMAL = 3'h0;
	localparam logic [2:0] LT_D215 = 3'h1;
	localparam logic [2:0] LT_K285 = 3'h2;
	localparam logic [2:0] LT_ILA = 3'h3;
	localparam logic [2:0] LT_RPAT = 3'h4;
	localparam logic [2:0] SC_SYSREF = 3'h1;
	localparam logic [2:0] SC_SYNC = 3'h2;
	// ****************************************
	// types
	// ****************************************
	typedef enum logic [1:0] {ST_SYNC = 2'b00, ST_ILA = 2'b01, ST_DATA = 2'b10} jtl_tx_state_type;
	typedef struct packed {
		logic [15:0] data;
		logic [1:0] k;
	} jtl_lane_type;
	typedef struct packed {
		logic readout, ovr_sel;
		logic [7:0] word2, trip, lane, ovrd, scr, oct, mfl, cls, resync, ltest;
		logic sclk_q, sdo, sdo_oe;
		logic [3:0] bit_cnt;
		logic [15:0] sh;
		logic [7:0] rd_sh;
		jtl_tx_state_type st;
		logic [1:0] mf_cnt;
		logic [4:0] lmfc;
		logic [14:0] prbs, scr_lfsr;
		logic [3:0] rpat_idx;
		logic [7:0] prev_lo;
		logic ch, sync_q, sysref_q, arm_q, armed;
		logic [1:0][7:0] ovr_sr;
		logic [1:0] ovr;
		logic div_rst, adiv_rst, flip;
		logic ov, sv;
		jtl_lane_type od, sd;
	} jtl_state_type;
endpackage

// file: rtl/jtl_link_cfg.sv
// serial link transmitter configuration, pattern generation and fast over-range
module jtl_link_cfg (
	// clock and reset
	input wire logic clk_sys_in,
	input wire logic sys_rst_in,
	// serial control port
	input wire logic spi_clk_in,
	input wire logic spi_data_in,
	input wire logic spi_en_n_in,
	output logic spi_dout_out,
	output logic spi_dout_oe_out,
	// converter samples and sync inputs
	input wire logic [1:0][15:0] adc_in,
	input wire logic sync_in,
	input wire logic sysref_in,
	// lane word stream
	output jtl_pkg::jtl_lane_type lane_out,
	output logic lane_valid_out,
	input wire logic lane_ready_in,
	// status and divider control
	output logic [1:0] ovr_out,
	output logic div_reset_out,
	output logic analog_div_reset_out,
	output logic disp_flip_out
);
	jtl_pkg::jtl_state_type s_r, s_nxt, s_nxt2;
	jtl_pkg::jtl_lane_type gen;
	logic [1:0] ovl_c, norm_c;
	logic push, pop, mf_end, pulse, pass, lmfc_rst;

	// ****************************************
	// register readback
	// ****************************************
	function automatic logic [7:0] rd_reg(input jtl_pkg::jtl_state_type s, input logic [7:0] a);
		logic [7:0] v;
		v = 8'h00;
		if (a == jtl_pkg::A_READOUT)
			v = {7'h00, s.readout};
		else if (a == jtl_pkg::A_OVR_SEL)
			v = {7'h00, s.ovr_sel};
		else if (a == jtl_pkg::A_WORD2)
			v = s.word2;
		else if (a == jtl_pkg::A_TRIP)
			v = s.trip;
		else if (a == jtl_pkg::A_LANE)
			v = s.lane;
		else if (a == jtl_pkg::A_OVRD)
			v = s.ovrd;
		else if (a == jtl_pkg::A_SCR)
			v = s.scr;
		else if (a == jtl_pkg::A_OCT)
			v = s.oct;
		else if (a == jtl_pkg::A_MFL)
			v = s.mfl;
		else if (a == jtl_pkg::A_CLASS)
			v = s.cls;
		else if (a == jtl_pkg::A_RESYNC)
			v = s.resync;
		else if (a == jtl_pkg::A_LTEST)
			v = s.ltest;
		return v;
	endfunction

	// ****************************************
	// fast over-range detect per channel
	// ****************************************
	genvar gi;
	generate
		for (gi = 0; gi < 2; gi++)
		begin : g_ch
			logic [14:0] mag;
			// one's complement magnitude avoids the overflow of negating the most negative code
			assign mag = adc_in[gi][15] ? ~adc_in[gi][14:0] : adc_in[gi][14:0];
			assign ovl_c[gi] = 23'(mag) * 23'(jtl_pkg::TRIP_DIV) >= 23'(s_r.trip) * 23'(jtl_pkg::FULL_SCALE);
			assign norm_c[gi] = (adc_in[gi] == 16'h7fff) || (adc_in[gi] == 16'h8000);
		end
	endgenerate

	// ****************************************
	// lane word generation
	// ****************************************
	always_comb
	begin
		logic [15:0] smp, d, pw;
		logic [14:0] p;
		logic [5:0] kk, sum;
		logic [1:0] fpw;
		logic b;
		b = 1'b0;
		smp = s_r.ch ? adc_in[1] : adc_in[0];
		if (s_r.lane[jtl_pkg::B_REVERSE])
			smp = {<<{smp}};
		fpw = (s_r.ovrd[jtl_pkg::B_CTRL_F] && s_r.oct[0]) ? 2'd1 : 2'd2;
		if (s_r.ovrd[jtl_pkg::B_CTRL_K])
			kk = {1'b0, s_r.mfl[4:0]};
		else
			kk = s_r.oct[0] ? {1'b0, jtl_pkg::K_DEF_20X} : {1'b0, jtl_pkg::K_DEF_10X};
		if (kk == 6'd0)
			kk = 6'd1;
		sum = 6'(s_r.lmfc) + 6'(fpw);
		mf_end = sum >= kk;
		p = s_r.prbs;
		for (int i = 15; i >= 0; i--)
		begin
			pw[i] = p[14];
			p = {p[13:0], p[14] ^ p[13]};
		end
		case (s_r.lane[7:6])
			2'b01: d = jtl_pkg::CLK_PAT;
			2'b10: d = {s_r.word2, s_r.word2};
			2'b11: d = pw;
			default: d = smp;
		endcase
		if (s_r.lane[jtl_pkg::B_LONG_TEST])
			d = {3'h0, s_r.lmfc, 7'h00, s_r.ch};
		gen.data = d;
		gen.k = 2'b00;
		if (s_r.scr[jtl_pkg::B_SCR_EN])
		begin
			p = s_r.scr_lfsr;
			for (int i = 15; i >= 0; i--)
			begin
				b = d[i] ^ p[13] ^ p[14];
				gen.data[i] = b;
				p = {p[13:0], b};
			end
		end
		if (mf_end && s_r.lane[jtl_pkg::B_LANE_MK] && gen.data[7:0] == s_r.prev_lo)
		begin
			gen.data[7:0] = jtl_pkg::K283;
			gen.k[0] = 1'b1;
		end
		else if (s_r.lane[jtl_pkg::B_FRAME_MK] && gen.data[7:0] == s_r.prev_lo)
		begin
			gen.data[7:0] = jtl_pkg::K287;
			gen.k[0] = 1'b1;
		end
		case (s_r.ltest[7:5])
			jtl_pkg::LT_D215:
			begin
				gen.data = {jtl_pkg::D215, jtl_pkg::D215};
				gen.k = 2'b00;
			end
			jtl_pkg::LT_K285:
			begin
				gen.data = {jtl_pkg::K285, jtl_pkg::K285};
				gen.k = 2'b11;
			end
			jtl_pkg::LT_RPAT:
			begin
				gen.data = {jtl_pkg::RPAT[s_r.rpat_idx], jtl_pkg::RPAT[s_r.rpat_idx + 4'd1]};
				gen.k = 2'b00;
			end
			default:
			begin
			end
		endcase
		if (s_r.st == jtl_pkg::ST_ILA)
		begin
			gen.data = 16'h0000;
			gen.k = 2'b00;
			if (s_r.lmfc == 5'd0)
			begin
				gen.data[15:8] = jtl_pkg::K280;
				gen.k[1] = 1'b1;
			end
			if (mf_end)
			begin
				gen.data[7:0] = jtl_pkg::K283;
				gen.k[0] = 1'b1;
			end
		end
		if (s_r.st == jtl_pkg::ST_SYNC || sync_in || s_r.resync[jtl_pkg::B_RESYNC])
		begin
			gen.data = s_r.lane[jtl_pkg::B_IDLE_SEL] ? jtl_pkg::IDLE_ALT : jtl_pkg::IDLE_STD;
			gen.k = s_r.lane[jtl_pkg::B_IDLE_SEL] ? 2'b10 : 2'b11;
		end
		s_nxt = s_r;
		s_nxt.lmfc = mf_end ? 5'(sum - kk) : sum[4:0];
		s_nxt.prbs = p;
		if (!s_r.scr[jtl_pkg::B_SCR_EN])
			s_nxt.scr_lfsr = s_r.scr_lfsr;
		s_nxt.prbs = s_r.prbs;
		// the lfsr copies are only committed below when a word is taken
		s_nxt.scr_lfsr = s_r.scr_lfsr;
		if (s_r.scr[jtl_pkg::B_SCR_EN])
			s_nxt.scr_lfsr = p;
		s_nxt.prbs = {pw[14:0] ^ 15'h0000};
		s_nxt.prbs = s_r.lane[7:6] == 2'b11 ? pw[15:1] : s_r.prbs;
	end

	// ****************************************
	// pulse filter, buffer, sequencing, serial port
	// ****************************************
	assign push = !s_r.sv; // generator stalls while the skid slot is full
	assign pop = s_r.ov && lane_ready_in;
	always_comb
	begin
		jtl_pkg::jtl_state_type n;
		logic [15:0] shn;
		logic [7:0] rv, wd;
		logic arm_rise;
		n = s_nxt;
		if (!push)
		begin
			n.lmfc = s_r.lmfc;
			n.prbs = s_r.prbs;
			n.scr_lfsr = s_r.scr_lfsr;
		end
		pulse = 1'b0;
		if (s_r.cls[7:5] == jtl_pkg::SC_SYSREF)
			pulse = sysref_in && !s_r.sysref_q;
		else if (s_r.cls[7:5] == jtl_pkg::SC_SYNC)
			pulse = sync_in && !s_r.sync_q;
		arm_rise = s_r.ltest[jtl_pkg::B_PF_ARM] && !s_r.arm_q;
		pass = pulse && (!s_r.ltest[jtl_pkg::B_PF_ONCE] || s_r.armed);
		n.armed = arm_rise || (s_r.armed && !pass);
		n.arm_q = s_r.ltest[jtl_pkg::B_PF_ARM];
		n.sync_q = sync_in;
		n.sysref_q = sysref_in;
		n.div_rst = pass;
		n.adiv_rst = pass && !s_r.ltest[jtl_pkg::B_PF_ANALOG];
		lmfc_rst = pass && !s_r.resync[jtl_pkg::B_LMFC_IGN];
		if (lmfc_rst)
			n.lmfc = 5'd0;
		n.flip = s_r.ltest[7:5] == jtl_pkg::LT_RPAT && s_r.ltest[jtl_pkg::B_FLIP];
		// two-entry skid buffer: output and skid slots are both flops
		if (!s_r.ov || pop)
		begin
			n.ov = s_r.sv || push;
			n.od = s_r.sv ? s_r.sd : gen;
			n.sv = 1'b0;
		end
		else if (push)
		begin
			n.sv = 1'b1;
			n.sd = gen;
		end
		if (push)
		begin
			n.ch = !s_r.ch;
			n.prev_lo = gen.data[7:0];
			n.rpat_idx = s_r.rpat_idx >= jtl_pkg::RPAT_LAST ? 4'd0 : s_r.rpat_idx + 4'd2;
			case (s_r.st)
				jtl_pkg::ST_SYNC:
					if (!sync_in)
					begin
						n.st = s_r.lane[jtl_pkg::B_ILA_OFF] ? jtl_pkg::ST_DATA : jtl_pkg::ST_ILA;
						n.mf_cnt = 2'd0;
					end
				jtl_pkg::ST_ILA:
					if (mf_end)
					begin
						n.mf_cnt = s_r.mf_cnt + 2'd1;
						if (s_r.mf_cnt == jtl_pkg::ILA_LAST_MF && s_r.ltest[7:5] != jtl_pkg::LT_ILA)
							n.st = jtl_pkg::ST_DATA;
					end
				default:
					if (s_r.ltest[7:5] == jtl_pkg::LT_ILA)
						n.st = jtl_pkg::ST_ILA;
			endcase
		end
		if (sync_in || s_r.resync[jtl_pkg::B_RESYNC])
			n.st = jtl_pkg::ST_SYNC;
		for (int c = 0; c < 2; c++)
		begin
			n.ovr_sr[c] = {s_r.ovr_sr[c][6:0], ovl_c[c]};
			n.ovr[c] = s_r.ovr_sel ? s_r.ovr_sr[c][7] : norm_c[c];
		end
		// serial port: address then data, msb first, bits taken on rising sclk
		n.sclk_q = spi_clk_in;
		shn = {s_r.sh[14:0], spi_data_in};
		rv = rd_reg(s_r, shn[7:0]);
		wd = shn[7:0];
		if (spi_en_n_in)
		begin
			n.bit_cnt = 4'd0;
			n.sdo_oe = 1'b0;
		end
		else if (spi_clk_in && !s_r.sclk_q)
		begin
			n.sh = shn;
			n.bit_cnt = s_r.bit_cnt + 4'd1;
			if (s_r.bit_cnt == 4'd7 && s_r.readout)
			begin
				n.sdo = rv[7];
				n.rd_sh = {rv[6:0], 1'b0};
				n.sdo_oe = 1'b1;
			end
			else if (s_r.bit_cnt > 4'd7)
			begin
				n.sdo = s_r.rd_sh[7];
				n.rd_sh = {s_r.rd_sh[6:0], 1'b0};
			end
			// readback mode blocks writes except to the readout control itself
			if (s_r.bit_cnt == 4'd15 && (!s_r.readout || shn[15:8] == jtl_pkg::A_READOUT))
			begin
				if (shn[15:8] == jtl_pkg::A_READOUT)
					n.readout = wd[0];
				else if (shn[15:8] == jtl_pkg::A_OVR_SEL)
					n.ovr_sel = wd[0];
				else if (shn[15:8] == jtl_pkg::A_WORD2)
					n.word2 = wd;
				else if (shn[15:8] == jtl_pkg::A_TRIP)
					n.trip = wd;
				else if (shn[15:8] == jtl_pkg::A_LANE)
					n.lane = wd;
				else if (shn[15:8] == jtl_pkg::A_OVRD)
					n.ovrd = wd & jtl_pkg::M_OVRD;
				else if (shn[15:8] == jtl_pkg::A_SCR)
					n.scr = wd & jtl_pkg::M_SCR;
				else if (shn[15:8] == jtl_pkg::A_OCT)
					n.oct = wd & jtl_pkg::M_BIT0;
				else if (shn[15:8] == jtl_pkg::A_MFL)
					n.mfl = wd & jtl_pkg::M_MFL;
				else if (shn[15:8] == jtl_pkg::A_CLASS)
					n.cls = wd & jtl_pkg::M_CLASS;
				else if (shn[15:8] == jtl_pkg::A_RESYNC)
					n.resync = wd & jtl_pkg::M_RESYNC;
				else if (shn[15:8] == jtl_pkg::A_LTEST)
					n.ltest = wd & jtl_pkg::M_LTEST;
			end
		end
		s_nxt2 = n;
	end

	always_ff @(posedge clk_sys_in)
	begin
		if (sys_rst_in)
		begin
			s_r <= '0;
			s_r.trip <= jtl_pkg::RST_TRIP;
			s_r.cls <= jtl_pkg::RST_CLASS;
			s_r.scr <= jtl_pkg::RST_ZERO;
			s_r.st <= jtl_pkg::ST_SYNC;
			s_r.prbs <= jtl_pkg::PRBS_SEED[14:0];
			s_r.scr_lfsr <= jtl_pkg::PRBS_SEED[14:0];
		end
		else
			s_r <= s_nxt2;
	end

	assign lane_out = s_r.od;
	assign lane_valid_out = s_r.ov;
	assign ovr_out = s_r.ovr;
	assign div_reset_out = s_r.div_rst;
	assign analog_div_reset_out = s_r.adiv_rst;
	assign disp_flip_out = s_r.flip;
	assign spi_dout_out = s_r.sdo;
	assign spi_dout_oe_out = s_r.sdo_oe;

	// ****************************************
	// assertions
	// ****************************************
	default clocking cb @(posedge clk_sys_in); endclocking
	default disable iff (sys_rst_in);
	a_ovr_fast_delay: assert property ((s_r.ovr_sel && ovl_c[0]) ##1 s_r.ovr_sel [*8] |=> ovr_out[0])
		else $error("fast over-range late");
	a_trip_reset_val: assert property ($fell(sys_rst_in) |-> s_r.trip == 8'hff)
		else $error("trip level reset wrong");
	a_idle_code_sel: assert property (sync_in |-> gen.data == (s_r.lane[5] ? 16'hbc50 : 16'hbcbc))
		else $error("idle code wrong");
	a_resync_forces: assert property (s_r.resync[7] |=> s_r.st == jtl_pkg::ST_SYNC)
		else $error("resync not honoured");
	a_ila_skip_data: assert property (s_r.st == jtl_pkg::ST_SYNC && !sync_in && !s_r.resync[7] && s_r.lane[0] && push
		|=> s_r.st == jtl_pkg::ST_DATA)
		else $error("alignment not skipped");
	a_lmfc_clear: assert property (lmfc_rst |=> s_r.lmfc == 5'd0)
		else $error("lmfc not cleared");
	a_lmfc_masked: assert property (pass && s_r.resync[6] && !push |=> $stable(s_r.lmfc))
		else $error("masked lmfc reset acted");
	a_analog_block: assert property ($past(s_r.ltest[2]) |-> !analog_div_reset_out)
		else $error("analog divider reset not blocked");
	a_class_zero: assert property ($past(s_r.cls[7:5] == 3'b000) |-> !div_reset_out)
		else $error("subclass 0 reset seen");
	a_flip_rpat: assert property (disp_flip_out |-> $past(s_r.ltest[7:5]) == 3'b100)
		else $error("flip outside rpat");
	a_buf_hold: assert property (lane_valid_out && !lane_ready_in |=> lane_valid_out && $stable(lane_out))
		else $error("lane word dropped");
	c_buf_full: cover property (s_r.ov && s_r.sv);
	c_to_data: cover property (s_r.st == jtl_pkg::ST_ILA ##1 s_r.st == jtl_pkg::ST_DATA);
	c_ovr_fire: cover property (s_r.ovr_sel && $rose(ovr_out[0]));
endmodule // jtl_link_cfg

// file: dv/jtl_rx_model.sv
// receiver-side model: lane word sink with stalls and sync drive
module jtl_rx_model (
	// clock and reset
	input wire logic clk_sys_in,
	input wire logic sys_rst_in,
	// lane stream
	input wire jtl_pkg::jtl_lane_type lane_in,
	input wire logic lane_valid_in,
	output logic lane_ready_out,
	// bench control
	input wire logic hold_in,
	input wire logic stall_en_in,
	input wire logic sync_req_in,
	output logic sync_out,
	output logic [7:0] err_count_out
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [15:0] lfsr_r;
	logic pend_r;
	jtl_pkg::jtl_lane_type last_r;
	initial lane_ready_out = 1'b0;
	// sync stays high until the bench says code group lock is reached
	assign sync_out = sync_req_in;
	// ready moves off the sampling edge; random stalls keep the skid buffer busy
	always @(negedge clk_sys_in)
	begin
		lfsr_r <= sys_rst_in ? 16'hace1 : {lfsr_r[14:0], lfsr_r[15] ^ lfsr_r[13] ^ lfsr_r[12] ^ lfsr_r[10]};
		lane_ready_out <= !sys_rst_in && !hold_in && !(stall_en_in && lfsr_r[0]);
	end
	always @(posedge clk_sys_in)
	begin
		if (sys_rst_in)
		begin
			err_count_out <= 8'h00;
			pend_r <= 1'b0;
		end
		else
		begin
			// a word offered and not taken must come again unchanged
			if (pend_r && (lane_valid_in !== 1'b1 || lane_in !== last_r))
				err_count_out <= err_count_out + 8'h01;
			pend_r <= lane_valid_in && !lane_ready_out;
			last_r <= lane_in;
		end
	end
endmodule // jtl_rx_model

// file: dv/jtl_link_cfg_tb.sv
// self-checking bench for the serial link configuration block
module jtl_link_cfg_tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic sclk = 1'b0;
	logic sdi = 1'b0;
	logic sen_n = 1'b1;
	logic sysref = 1'b0;
	logic hold = 1'b0;
	logic stall_en = 1'b0;
	logic sync_req = 1'b1;
	logic [1:0][15:0] adc = '0;
	logic sdo, sdo_oe, sync_l, ready, valid, divr, adivr, flip;
	logic [1:0] ovr;
	logic [7:0] err_cnt;
	jtl_pkg::jtl_lane_type lane;
	int fail_count = 0;
	int checks = 0;
	logic [31:0] seed = 32'h60a51a79;
	// address, reset value, kept bits
	logic [23:0] tbl [11] = '{24'h1300ff, 24'h1fffff, 24'h2600ff, 24'h270003, 24'h280080, 24'h2c0001,
		24'h2d001f, 24'h3040e0, 24'h3600c0, 24'h3700f7, 24'h500000};
	always #5 clk = ~clk;
	jtl_link_cfg i_jtl_link_cfg (
		.clk_sys_in(clk),
		.sys_rst_in(rst),
		.spi_clk_in(sclk),
		.spi_data_in(sdi),
		.spi_en_n_in(sen_n),
		.spi_dout_out(sdo),
		.spi_dout_oe_out(sdo_oe),
		.adc_in(adc),
		.sync_in(sync_l),
		.sysref_in(sysref),
		.lane_out(lane),
		.lane_valid_out(valid),
		.lane_ready_in(ready),
		.ovr_out(ovr),
		.div_reset_out(divr),
		.analog_div_reset_out(adivr),
		.disp_flip_out(flip)
	);
	jtl_rx_model i_jtl_rx_model (
		.clk_sys_in(clk),
		.sys_rst_in(rst),
		.lane_in(lane),
		.lane_valid_in(valid),
		.lane_ready_out(ready),
		.hold_in(hold),
		.stall_en_in(stall_en),
		.sync_req_in(sync_req),
		.sync_out(sync_l),
		.err_count_out(err_cnt)
	);
	// ****************************************
	// helpers
	// ****************************************
	function automatic logic [31:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction
	task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
		checks++;
		if (got !== exp)
		begin
			fail_count++;
			$display("wrong value %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic give_verdict();
		$display("checks %0d fail_count %0d", checks, fail_count);
		if (fail_count == 0 && checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	// sclk held two cycles per phase since the port samples it as plain data
	task automatic spi(input logic [7:0] a, input logic [7:0] d, output logic [7:0] rd);
		logic [15:0] w;
		w = {a, d};
		rd = 8'h00;
		sen_n = 1'b0;
		for (int i = 0; i < 16; i++)
		begin
			sdi = w[15 - i];
			repeat (2) @(negedge clk);
			if (i >= 8)
				rd = {rd[6:0], sdo};
			sclk = 1'b1;
			repeat (2) @(negedge clk);
			sclk = 1'b0;
		end
		repeat (2) @(negedge clk);
		sen_n = 1'b1;
		@(negedge clk);
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		logic [7:0] x;
		spi(a, d, x);
	endtask
	task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
		logic [7:0] x;
		spi(a, 8'h00, x);
		check($sformatf("reg %h", a), {8'h00, e}, {8'h00, x});
	endtask
	task automatic take(output jtl_pkg::jtl_lane_type w);
		int n;
		n = 0;
		do
		begin
			@(posedge clk);
			n++;
		end
		while (!(valid === 1'b1 && ready === 1'b1) && n < 100);
		w = lane;
		@(negedge clk);
	endtask
	task automatic expect_words(input string what, input logic [15:0] exp);
		jtl_pkg::jtl_lane_type w;
		repeat (8) take(w);
		repeat (4)
		begin
			take(w);
			check(what, exp, w.data);
		end
	endtask
	task automatic first_word(output jtl_pkg::jtl_lane_type w);
		int n;
		n = 0;
		do
		begin
			take(w);
			n++;
		end
		while (w.k !== 2'b00 && n < 40);
	endtask
	task automatic find_char(input string what, input logic [7:0] c);
		jtl_pkg::jtl_lane_type w;
		logic hit;
		hit = 1'b0;
		repeat (80)
		begin
			take(w);
			hit = hit | (w.k[1] && w.data[15:8] == c) | (w.k[0] && w.data[7:0] == c);
		end
		check(what, 16'h0001, {15'h0000, hit});
	endtask
	task automatic pulse(inout int nd, inout int na);
		for (int i = 0; i < 14; i++)
		begin
			sysref = i < 4;
			@(negedge clk);
			nd += int'(divr === 1'b1);
			na += int'(adivr === 1'b1);
		end
	endtask
	// ****************************************
	// scenarios
	// ****************************************
	initial
	begin
		jtl_pkg::jtl_lane_type w;
		logic [7:0] v;
		logic [7:0] ex [11];
		logic [15:0] s;
		logic [15:0] r16;
		int nd;
		int na;
		repeat (6) @(negedge clk);
		rst = 1'b0;
		@(negedge clk);
		wr(8'h00, 8'h01);
		for (int k = 0; k < 11; k++)
			rd_chk(tbl[k][23:16], tbl[k][15:8]);
		wr(8'h13, 8'h5a);
		rd_chk(8'h13, 8'h00);
		wr(8'h00, 8'h00);
		for (int k = 0; k < 11; k++)
		begin
			v = 8'(rnd());
			if (tbl[k][23:16] == 8'h2d)
				v = v | 8'h11;
			if (tbl[k][23:16] == 8'h30)
				v = v & 8'h5f;
			wr(tbl[k][23:16], v);
			ex[k] = v & tbl[k][7:0];
		end
		wr(8'h00, 8'h01);
		for (int k = 0; k < 11; k++)
			rd_chk(tbl[k][23:16], ex[k]);
		rst = 1'b1;
		repeat (2) @(negedge clk);
		rst = 1'b0;
		stall_en = 1'b1;
		expect_words("idle std", 16'hbcbc);
		wr(8'h26, 8'h20);
		expect_words("idle alt", 16'hbc50);
		wr(8'h26, 8'h41);
		sync_req = 1'b0;
		first_word(w);
		check("clock pattern", 16'haaaa, w.data);
		s = 16'(rnd());
		r16 = {<<{s}};
		wr(8'h13, s[7:0]);
		wr(8'h26, 8'h81);
		expect_words("encoded", {s[7:0], s[7:0]});
		adc = {s, s};
		wr(8'h26, 8'h01);
		expect_words("normal", s);
		wr(8'h26, 8'h09);
		expect_words("reversed", r16);
		wr(8'h26, 8'hc1);
		wr(8'h26, 8'h01);
		wr(8'h37, 8'h20);
		expect_words("link d21.5", 16'hb5b5);
		wr(8'h37, 8'h40);
		expect_words("link k28.5", 16'hbcbc);
		wr(8'h37, 8'h60);
		find_char("repeat ila", 8'h1c);
		wr(8'h37, 8'h90);
		check("flip on", 16'h0001, {15'h0000, flip});
		wr(8'h37, 8'h10);
		check("flip off", 16'h0000, {15'h0000, flip});
		wr(8'h37, 8'h00);
		// long receiver stall: buffer fills, nothing may be lost
		hold = 1'b1;
		repeat (12) @(negedge clk);
		check("valid held", 16'h0001, {15'h0000, valid});
		hold = 1'b0;
		wr(8'h36, 8'h80);
		expect_words("resync idle", 16'hbcbc);
		wr(8'h36, 8'h00);
		wr(8'h26, 8'h05);
		find_char("lane marker", 8'h7c);
		wr(8'h26, 8'h03);
		find_char("frame marker", 8'hfc);
		wr(8'h26, 8'h01);
		wr(8'h0d, 8'h01);
		wr(8'h1f, 8'h80);
		adc = {2{16'h4000}};
		repeat (12) @(negedge clk);
		check("below trip", 16'h0000, {14'h0000, ovr});
		adc = {2{16'h4100}};
		repeat (7) @(negedge clk);
		check("ovr early", 16'h0000, {14'h0000, ovr});
		repeat (3) @(negedge clk);
		check("ovr late", 16'h0003, {14'h0000, ovr});
		adc = '0;
		wr(8'h30, 8'h20);
		nd = 0;
		na = 0;
		pulse(nd, na);
		check("div pulse", 16'h0001, {15'h0000, nd > 0});
		check("analog pulse", 16'h0001, {15'h0000, na > 0});
		wr(8'h37, 8'h04);
		na = 0;
		pulse(nd, na);
		check("analog blocked", 16'h0000, 16'(na));
		wr(8'h37, 8'h01);
		wr(8'h37, 8'h03);
		nd = 0;
		pulse(nd, na);
		pulse(nd, na);
		check("single pulse", 16'h0001, 16'(nd));
		wr(8'h37, 8'h00);
		sync_req = 1'b1;
		wr(8'h26, 8'h00);
		repeat (8) take(w);
		sync_req = 1'b0;
		find_char("ila start", 8'h1c);
		check("hold errors", 16'h0000, {8'h00, err_cnt});
		give_verdict();
	end
	// the whole run needs well under 20000 cycles
	initial
	begin
		#500000;
		fail_count++;
		give_verdict();
	end
endmodule // jtl_link_cfg_tb
